// ---- rtl/cra_pkg.sv ----
// constants, types and field layouts for the cpu status and addressing unit
// Functional notes
// - odd_ones_flag follows the accumulator: 1 for an odd count of ones
// - bank_select_hi at bit 4 and bank_select_lo at bit 3 pick one of four banks
// - status word bits: carry 7, aux 6, user0 5, excess 2, user1 1, odd 0
// - carry is arithmetic carry and the one-bit accumulator of bit operations
// - register form: 3-bit number from opcode selects register in active bank
// - 8-bit indirect address comes from R0, R1 or stack_pointer only
// - 16-bit indirect address comes only from data_pointer_pair
// - direct address is 8-bit and reaches internal RAM and special registers only
// - indexed access only reads program memory: pointer or pc plus accumulator
// - indexed jump target is base pointer plus accumulator
// - timing counted in plain clocks; an instruction takes one to seven clocks
// - long external space maps onto 1024 bytes of expanded_ram when selected
// - paged external space is 256 bytes overlapping the bottom of expanded_ram
// - internal RAM: 128 bytes direct or indirect, 256 bytes indirect in total
// - special registers answer only to direct addressing
// - program memory spans 64K, reached by fetch and by code move
// - direct above 7Fh hits special registers, indirect hits upper RAM
// - lowest 32 bytes form four banks of eight working registers
package cra_pkg;
    // special register offsets on the direct space and the register port
    localparam logic [7:0] CRA_OFS_SP = 8'h81;
    localparam logic [7:0] CRA_OFS_DPL = 8'h82;
    localparam logic [7:0] CRA_OFS_DPH = 8'h83;
    localparam logic [7:0] CRA_OFS_PSW = 8'hD0;
    localparam logic [7:0] CRA_OFS_B = 8'hF0;
    // values after reset
    localparam logic [7:0] CRA_RST_SP = 8'h07;
    localparam logic [7:0] CRA_RST_DP = 8'h00;
    localparam logic [7:0] CRA_RST_B = 8'h00;
    localparam logic [7:0] CRA_RST_PSW = 8'h00;
    // status word bit positions
    localparam int CRA_PSW_CY = 7;
    localparam int CRA_PSW_AC = 6;
    localparam int CRA_PSW_F0 = 5;
    localparam int CRA_PSW_RS1 = 4;
    localparam int CRA_PSW_RS0 = 3;
    localparam int CRA_PSW_OV = 2;
    localparam int CRA_PSW_F1 = 1;
    localparam int CRA_PSW_P = 0;
    // address space limits
    localparam logic [7:0] CRA_LOW_TOP = 8'h7F;
    localparam int CRA_IRAM_BYTES = 256;
    localparam int CRA_EXPANDED_RAM_BYTES = 1024;
    localparam logic [7:0] CRA_FILL = 8'hFF;
    // instruction length bounds in clocks
    localparam logic [2:0] CRA_MIN_CLK = 3'h1;
    localparam logic [2:0] CRA_MAX_CLK = 3'h7;

    // operations accepted on the operand port
    typedef enum logic [4:0] {
        CRA_OP_NONE, CRA_OP_DIR_RD, CRA_OP_DIR_WR, CRA_OP_IND_RD,
        CRA_OP_IND_WR, CRA_OP_REG_RD, CRA_OP_REG_WR, CRA_OP_PUSH,
        CRA_OP_POP, CRA_OP_PX_RD, CRA_OP_PX_WR, CRA_OP_XD_RD,
        CRA_OP_XD_WR, CRA_OP_CODE_DP, CRA_OP_CODE_PC, CRA_OP_JMP_DP,
        CRA_OP_SETC, CRA_OP_CLRC, CRA_OP_ANLC, CRA_OP_ORLC,
        CRA_OP_FLAGS, CRA_OP_FETCH
    } cra_op_t;

    // sequencing of an instruction slot
    typedef enum logic {
        CRA_IDLE, CRA_BUSY
    } cra_state_t;
endpackage

// ---- rtl/cra_core.sv ----
// cpu status word, pointers and operand addressing with internal memories
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module cra_core #(
    parameter int EXPANDED_RAM_BYTES = cra_pkg::CRA_EXPANDED_RAM_BYTES
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [7:0] acc,
    input wire logic ext_sel,
    input wire logic op_valid,
    input wire cra_pkg::cra_op_t op_code,
    input wire logic [7:0] op_addr,
    input wire logic [2:0] op_reg,
    input wire logic [7:0] op_data,
    input wire logic [15:0] op_pc,
    input wire logic [2:0] op_clocks,
    output logic op_ready,
    output logic res_valid,
    output logic [7:0] res_data,
    output logic res_ext,
    output logic [15:0] jmp_target,
    output logic jmp_valid,
    output logic [15:0] code_addr,
    output logic code_rd,
    output logic instr_done,
    output logic [7:0] psw_out
);
    // expanded_ram index width; long addresses are cut to it, paged addresses are widened to it
    localparam int XW = $clog2(EXPANDED_RAM_BYTES);

    typedef struct packed {
        cra_pkg::cra_state_t st;
        logic ready;
        logic [2:0] cnt;
        logic [7:0] sp;
        logic [7:0] data_pointer_low_byte;
        logic [7:0] data_pointer_high_byte;
        logic [7:0] b;
        logic [7:0] program_status_word;
        logic [7:0] rdata;
        logic res_valid;
        logic [7:0] res_data;
        logic res_ext;
        logic [15:0] jmp_target;
        logic jmp_valid;
        logic [15:0] code_addr;
        logic code_rd;
        logic instr_done;
    } cra_state_s_t;

    // registered state and its next value
    cra_state_s_t cur;
    cra_state_s_t next_cur;

    // internal RAM and expanded_ram, one write port each
    logic [7:0] iram [cra_pkg::CRA_IRAM_BYTES];
    logic [7:0] expanded_ram [EXPANDED_RAM_BYTES];

    // write port controls chosen by the operand decode
    logic iram_we;
    logic [7:0] iram_wa;
    logic [7:0] iram_wd;
    logic expanded_ram_we;
    logic [XW-1:0] expanded_ram_wa;
    logic [7:0] expanded_ram_wd;

    // address helpers
    logic [7:0] bank_base;
    logic [7:0] reg_loc;
    logic [7:0] ri_loc;
    logic [7:0] ri_val;
    logic [15:0] data_pointer_pair;
    logic [7:0] sp_inc;
    logic take;

    // special register read by direct offset, unmapped reads as zero
    // shared by the register port and direct operand reads
    function automatic logic [7:0] sfr_rd(input logic [7:0] a,
                                          input cra_state_s_t s);
        logic [7:0] v;
        v = 8'h00;
        case (a)
            cra_pkg::CRA_OFS_SP: v = s.sp;
            cra_pkg::CRA_OFS_DPL: v = s.data_pointer_low_byte;
            cra_pkg::CRA_OFS_DPH: v = s.data_pointer_high_byte;
            cra_pkg::CRA_OFS_B: v = s.b;
            cra_pkg::CRA_OFS_PSW: v = s.program_status_word;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // address helpers shared by all operand forms
    always_comb begin
        // four banks of eight in the lowest 32 bytes
        bank_base = {3'h0, cur.program_status_word[cra_pkg::CRA_PSW_RS1],
                     cur.program_status_word[cra_pkg::CRA_PSW_RS0], 3'h0};
        reg_loc = bank_base | {5'h00, op_reg};
        // only R0 or R1 may hold an 8-bit pointer
        ri_loc = bank_base | {7'h00, op_reg[0]};
        ri_val = iram[ri_loc];
        // pointer pair is high over low
        data_pointer_pair = {cur.data_pointer_high_byte, cur.data_pointer_low_byte};
        // stack grows upward
        sp_inc = cur.sp + 8'h01;
        // a request is taken only while no slot is running
        take = op_valid && (cur.st == cra_pkg::CRA_IDLE);
    end

    // next state: register port, operand port and instruction timing
    always_comb begin
        next_cur = cur;
        iram_we = 1'b0;
        iram_wa = 8'h00;
        iram_wd = op_data;
        expanded_ram_we = 1'b0;
        expanded_ram_wa = '0;
        expanded_ram_wd = op_data;
        next_cur.rdata = 8'h00;
        next_cur.res_valid = 1'b0;
        next_cur.res_ext = 1'b0;
        next_cur.jmp_valid = 1'b0;
        next_cur.code_rd = 1'b0;
        next_cur.instr_done = 1'b0;

        // software register port, read data stands one cycle
        // an operand write later in this process beats a port write
        if (reg_rd) begin
            next_cur.rdata = sfr_rd(reg_addr, cur);
        end
        if (reg_wr) begin
            case (reg_addr)
                cra_pkg::CRA_OFS_SP: next_cur.sp = reg_wdata;
                cra_pkg::CRA_OFS_DPL: next_cur.data_pointer_low_byte = reg_wdata;
                cra_pkg::CRA_OFS_DPH: next_cur.data_pointer_high_byte = reg_wdata;
                cra_pkg::CRA_OFS_B: next_cur.b = reg_wdata;
                cra_pkg::CRA_OFS_PSW: next_cur.program_status_word = reg_wdata;
                default: next_cur.sp = next_cur.sp;
            endcase
        end

        // requests while busy are ignored since take needs the idle state
        // slot length counted in plain clocks, one to seven
        case (cur.st)
            cra_pkg::CRA_IDLE: begin
                if (take) begin
                    if (op_clocks <= cra_pkg::CRA_MIN_CLK) begin
                        next_cur.instr_done = 1'b1;
                    end else begin
                        next_cur.st = cra_pkg::CRA_BUSY;
                        next_cur.cnt = op_clocks - cra_pkg::CRA_MIN_CLK;
                    end
                end
            end
            cra_pkg::CRA_BUSY: begin
                // count down the remaining clocks of the slot
                next_cur.cnt = cur.cnt - 3'h1;
                if (cur.cnt == 3'h1) begin
                    next_cur.st = cra_pkg::CRA_IDLE;
                    next_cur.instr_done = 1'b1;
                end
            end
            default: next_cur.st = cra_pkg::CRA_IDLE;
        endcase

        // operand decode, one operation per taken slot
        if (take) begin
            case (op_code)
                // direct space: internal RAM or special registers
                cra_pkg::CRA_OP_DIR_RD: begin
                    next_cur.res_valid = 1'b1;
                    // above 7Fh direct reaches special registers
                    if (op_addr > cra_pkg::CRA_LOW_TOP) begin
                        next_cur.res_data = sfr_rd(op_addr, cur);
                    end else begin
                        next_cur.res_data = iram[op_addr];
                    end
                end
                cra_pkg::CRA_OP_DIR_WR: begin
                    if (op_addr > cra_pkg::CRA_LOW_TOP) begin
                        case (op_addr)
                            cra_pkg::CRA_OFS_SP: next_cur.sp = op_data;
                            cra_pkg::CRA_OFS_DPL: next_cur.data_pointer_low_byte = op_data;
                            cra_pkg::CRA_OFS_DPH: next_cur.data_pointer_high_byte = op_data;
                            cra_pkg::CRA_OFS_B: next_cur.b = op_data;
                            cra_pkg::CRA_OFS_PSW: next_cur.program_status_word = op_data;
                            default: next_cur.b = next_cur.b;
                        endcase
                    end else begin
                        iram_we = 1'b1;
                        iram_wa = op_addr;
                    end
                end
                // indirect reaches all 256 bytes of internal RAM
                cra_pkg::CRA_OP_IND_RD: begin
                    next_cur.res_valid = 1'b1;
                    next_cur.res_data = iram[ri_val];
                end
                cra_pkg::CRA_OP_IND_WR: begin
                    iram_we = 1'b1;
                    iram_wa = ri_val;
                end
                cra_pkg::CRA_OP_REG_RD: begin
                    next_cur.res_valid = 1'b1;
                    next_cur.res_data = iram[reg_loc];
                end
                cra_pkg::CRA_OP_REG_WR: begin
                    iram_we = 1'b1;
                    iram_wa = reg_loc;
                end
                cra_pkg::CRA_OP_PUSH: begin
                    next_cur.sp = sp_inc;
                    iram_we = 1'b1;
                    iram_wa = sp_inc;
                end
                cra_pkg::CRA_OP_POP: begin
                    next_cur.res_valid = 1'b1;
                    next_cur.res_data = iram[cur.sp];
                    next_cur.sp = cur.sp - 8'h01;
                end
                // ext_sel high sends the access off chip: reads return
                // the fill value and writes are dropped
                // paged space overlaps the bottom of expanded_ram
                cra_pkg::CRA_OP_PX_RD: begin
                    next_cur.res_valid = 1'b1;
                    next_cur.res_ext = ext_sel;
                    next_cur.res_data = ext_sel ? cra_pkg::CRA_FILL :
                                        expanded_ram[XW'(ri_val)];
                end
                cra_pkg::CRA_OP_PX_WR: begin
                    next_cur.res_ext = ext_sel;
                    expanded_ram_we = !ext_sel;
                    expanded_ram_wa = XW'(ri_val);
                end
                // long space addressed only by the pointer pair
                cra_pkg::CRA_OP_XD_RD: begin
                    next_cur.res_valid = 1'b1;
                    next_cur.res_ext = ext_sel;
                    next_cur.res_data = ext_sel ? cra_pkg::CRA_FILL :
                                        expanded_ram[data_pointer_pair[XW-1:0]];
                end
                cra_pkg::CRA_OP_XD_WR: begin
                    next_cur.res_ext = ext_sel;
                    expanded_ram_we = !ext_sel;
                    expanded_ram_wa = data_pointer_pair[XW-1:0];
                end
                // program memory sits outside, only the address leaves
                // indexed read of program memory, never a write
                cra_pkg::CRA_OP_CODE_DP: begin
                    next_cur.code_rd = 1'b1;
                    next_cur.code_addr = data_pointer_pair + {8'h00, acc};
                end
                cra_pkg::CRA_OP_CODE_PC: begin
                    next_cur.code_rd = 1'b1;
                    next_cur.code_addr = op_pc + {8'h00, acc};
                end
                // instruction fetch from the 64K code space
                cra_pkg::CRA_OP_FETCH: begin
                    next_cur.code_rd = 1'b1;
                    next_cur.code_addr = op_pc;
                end
                // jump target is pointer plus accumulator
                cra_pkg::CRA_OP_JMP_DP: begin
                    next_cur.jmp_valid = 1'b1;
                    next_cur.jmp_target = data_pointer_pair + {8'h00, acc};
                end
                cra_pkg::CRA_OP_SETC: next_cur.program_status_word[cra_pkg::CRA_PSW_CY] = 1'b1;
                cra_pkg::CRA_OP_CLRC: next_cur.program_status_word[cra_pkg::CRA_PSW_CY] = 1'b0;
                cra_pkg::CRA_OP_ANLC: begin
                    next_cur.program_status_word[cra_pkg::CRA_PSW_CY] =
                        cur.program_status_word[cra_pkg::CRA_PSW_CY] & op_data[0];
                end
                cra_pkg::CRA_OP_ORLC: begin
                    next_cur.program_status_word[cra_pkg::CRA_PSW_CY] =
                        cur.program_status_word[cra_pkg::CRA_PSW_CY] | op_data[0];
                end
                // arithmetic carry, aux carry and excess from the alu
                cra_pkg::CRA_OP_FLAGS: begin
                    next_cur.program_status_word[cra_pkg::CRA_PSW_CY] = op_data[2];
                    next_cur.program_status_word[cra_pkg::CRA_PSW_AC] = op_data[1];
                    next_cur.program_status_word[cra_pkg::CRA_PSW_OV] = op_data[0];
                end
                default: next_cur.res_valid = 1'b0;
            endcase
        end

        // parity is rewritten every clock, so software writes to it are lost
        // odd ones flag tracks the accumulator every clock
        next_cur.program_status_word[cra_pkg::CRA_PSW_P] = ^acc;
        // ready is registered so the port comes straight from a flop
        next_cur.ready = (next_cur.st == cra_pkg::CRA_IDLE);
    end

    // state register
    always_ff @(posedge mclk) begin
        // reset loads the pointer and status defaults
        if (rst) begin
            cur <= '0;
            cur.st <= cra_pkg::CRA_IDLE;
            cur.ready <= 1'b1;
            cur.sp <= cra_pkg::CRA_RST_SP;
            cur.data_pointer_low_byte <= cra_pkg::CRA_RST_DP;
            cur.data_pointer_high_byte <= cra_pkg::CRA_RST_DP;
            cur.b <= cra_pkg::CRA_RST_B;
            cur.program_status_word <= cra_pkg::CRA_RST_PSW;
        end else begin
            cur <= next_cur;
        end
    end

    // memory write ports, contents are not cleared by reset
    // one write per clock into each memory
    always_ff @(posedge mclk) begin
        if (iram_we) begin
            iram[iram_wa] <= iram_wd;
        end
        if (expanded_ram_we) begin
            expanded_ram[expanded_ram_wa] <= expanded_ram_wd;
        end
    end

    // outputs straight from the state register
    assign reg_rdata = cur.rdata;
    assign op_ready = cur.ready;
    assign res_valid = cur.res_valid;
    assign res_data = cur.res_data;
    assign res_ext = cur.res_ext;
    assign jmp_target = cur.jmp_target;
    assign jmp_valid = cur.jmp_valid;
    assign code_addr = cur.code_addr;
    assign code_rd = cur.code_rd;
    assign instr_done = cur.instr_done;
    assign psw_out = cur.program_status_word;
endmodule

// ---- dv/cra_core_sva.sv ----
// port checker for the status and addressing unit
`timescale 1ns/1ps
module cra_core_sva #(
    parameter int EXPANDED_RAM_BYTES = 1024
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [7:0] acc,
    input wire logic ext_sel,
    input wire logic op_valid,
    input wire cra_pkg::cra_op_t op_code,
    input wire logic [15:0] op_pc,
    input wire logic [2:0] op_clocks,
    input wire logic op_ready,
    input wire logic res_valid,
    input wire logic [7:0] res_data,
    input wire logic res_ext,
    input wire logic jmp_valid,
    input wire logic [15:0] code_addr,
    input wire logic code_rd,
    input wire logic instr_done,
    input wire logic [7:0] psw_out
);
    logic take;
    // request accepted at this edge
    assign take = op_valid && op_ready;
    default clocking dcb @(posedge mclk);
    endclocking
    default disable iff (rst);
    a_parity_tracks: assert property (
        !$past(rst) |-> psw_out[0] == ^$past(acc))
        else $error("parity bit lags the accumulator");
    a_rdata_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (
        $past(reg_rd) && !($past(reg_addr) inside
        {8'h81, 8'h82, 8'h83, 8'hD0, 8'hF0}) |-> reg_rdata == 8'h00)
        else $error("unmapped offset read non zero");
    a_busy_after_take: assert property (
        take && op_clocks > 3'h1 |=> !op_ready)
        else $error("ready during a long slot");
    a_done_short: assert property (
        take && op_clocks <= 3'h1 |=> instr_done)
        else $error("one clock slot not done");
    a_done_long: assert property (
        take && op_clocks == 3'h7 |=> !instr_done [*6] ##1 instr_done)
        else $error("seven clock slot wrong length");
    a_code_index: assert property (
        take && op_code == cra_pkg::CRA_OP_CODE_PC |=>
        code_rd && code_addr == $past(op_pc) + {8'h00, $past(acc)})
        else $error("pc indexed code address wrong");
    a_jump_pulse: assert property (
        take && op_code == cra_pkg::CRA_OP_JMP_DP |=> jmp_valid)
        else $error("indexed jump gave no target");
    a_ext_reads_ff: assert property (
        take && ext_sel && op_code inside {cra_pkg::CRA_OP_PX_RD,
        cra_pkg::CRA_OP_XD_RD} |=> res_valid && res_ext && res_data == 8'hFF)
        else $error("external read not flagged");
    a_carry_ops: assert property (
        take && op_code inside {cra_pkg::CRA_OP_SETC, cra_pkg::CRA_OP_CLRC}
        |=> psw_out[7] == ($past(op_code) == cra_pkg::CRA_OP_SETC))
        else $error("carry set or clear failed");
    a_reset_vals: assert property (
        $past(rst) |-> op_ready && !res_valid && psw_out == 8'h00)
        else $error("state after reset wrong");
    c_push: cover property (take && op_code == cra_pkg::CRA_OP_PUSH);
    c_pop: cover property (take && op_code == cra_pkg::CRA_OP_POP);
    c_jump: cover property (jmp_valid);
    c_ext: cover property (res_ext);
endmodule
bind cra_core cra_core_sva #(.EXPANDED_RAM_BYTES(EXPANDED_RAM_BYTES)) u_sva (.*);

// ---- dv/cra_core_test.sv ----
// self-checking bench for the status and addressing unit
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; \
    $display("MISMATCH %s expected %h seen %h", n, e, g); end end
module cra_core_test;
    logic mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic ext_sel = 1'b0, op_valid = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, acc = 8'h00;
    logic [7:0] op_addr = 8'h00, op_data = 8'h00;
    logic [2:0] op_reg = 3'h0, op_clocks = 3'h1;
    logic [15:0] op_pc = 16'h0000, jmp_target, code_addr;
    logic [7:0] reg_rdata, res_data, psw_out, rd, res;
    logic op_ready, res_valid, res_ext, jmp_valid, code_rd, instr_done;
    logic rx, jv, cr;
    cra_pkg::cra_op_t op_code = cra_pkg::CRA_OP_NONE;
    int failures = 0, checks = 0, nd;
    cra_core dut (.*);
    // free-running 50 MHz clock
    initial forever #10 mclk = ~mclk;
    task automatic end_sim();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic cyc();
        @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdr(input logic [7:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
    endtask
    // one operand request; nd counts clocks up to the end of the slot
    task automatic op(input cra_pkg::cra_op_t c, input logic [7:0] d,
                      input logic [2:0] r, input logic [2:0] n);
        @(posedge mclk);
        op_valid <= 1'b1;
        op_code <= c;
        op_data <= d;
        op_addr <= d;
        op_reg <= r;
        op_clocks <= n;
        @(posedge mclk);
        op_valid <= 1'b0;
        #1 {res, rx, jv, cr} = {res_data, res_ext, jmp_valid, code_rd};
        for (nd = 1; !instr_done && nd < 9; nd++) cyc();
        `CHK("slot end", 1'b1, instr_done)
        if (!instr_done) end_sim();
        for (int k = 0; !op_ready; k++) begin
            if (k > 20) begin
                failures++;
                end_sim();
            end
            cyc();
        end
    endtask
    task automatic t_regs();
        logic [7:0] ofs [5] = '{8'h81, 8'h82, 8'h83, 8'hD0, 8'hF0};
        logic [7:0] ini [5] = '{8'h07, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 5; i++) begin
            rdr(ofs[i]);
            `CHK("reset value", ini[i], rd)
            wr(ofs[i], 8'(8'h3D + i));
            rdr(ofs[i]);
            `CHK("readback", 8'(8'h3D + i) & (i == 3 ? 8'hFE : 8'hFF), rd)
        end
        wr(8'h90, 8'h5A);
        rdr(8'h90);
        `CHK("unmapped", 8'h00, rd)
        wr(8'h81, 8'h07);
    endtask
    task automatic t_parity();
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            acc <= 8'(i * 37);
            cyc();
            cyc();
            `CHK("parity", ^(8'(i * 37)), psw_out[0])
        end
    endtask
    task automatic t_banks();
        for (int b = 0; b < 4; b++) begin
            wr(8'hD0, 8'(b << 3));
            op(cra_pkg::CRA_OP_REG_WR, 8'(8'hA0 + b), 3'h5, 3'h1);
        end
        for (int b = 0; b < 4; b++) begin
            wr(8'hD0, 8'(b << 3));
            op(cra_pkg::CRA_OP_REG_RD, 8'h00, 3'h5, 3'h1);
            `CHK("bank reg", 8'(8'hA0 + b), res)
            op(cra_pkg::CRA_OP_DIR_RD, 8'(b * 8 + 5), 3'h0, 3'h1);
            `CHK("bank byte", 8'(8'hA0 + b), res)
        end
        wr(8'hD0, 8'h00);
    endtask
    task automatic t_indirect();
        op(cra_pkg::CRA_OP_REG_WR, 8'h90, 3'h0, 3'h1);
        op(cra_pkg::CRA_OP_IND_WR, 8'h3C, 3'h0, 3'h1);
        op(cra_pkg::CRA_OP_IND_RD, 8'h00, 3'h0, 3'h1);
        `CHK("upper ram", 8'h3C, res)
        op(cra_pkg::CRA_OP_DIR_RD, 8'h90, 3'h0, 3'h1);
        `CHK("direct upper", 8'h00, res)
        op(cra_pkg::CRA_OP_DIR_RD, 8'h81, 3'h0, 3'h1);
        `CHK("direct sfr", 8'h07, res)
        op(cra_pkg::CRA_OP_REG_WR, 8'h7F, 3'h1, 3'h1);
        op(cra_pkg::CRA_OP_IND_WR, 8'h66, 3'h1, 3'h1);
        op(cra_pkg::CRA_OP_DIR_RD, 8'h7F, 3'h0, 3'h1);
        `CHK("lower ram", 8'h66, res)
    endtask
    task automatic t_stack();
        op(cra_pkg::CRA_OP_PUSH, 8'h55, 3'h0, 3'h2);
        rdr(8'h81);
        `CHK("sp push", 8'h08, rd)
        op(cra_pkg::CRA_OP_POP, 8'h00, 3'h0, 3'h1);
        `CHK("pop data", 8'h55, res)
        rdr(8'h81);
        `CHK("sp pop", 8'h07, rd)
    endtask
    task automatic t_expanded_ram();
        wr(8'h83, 8'h01);
        wr(8'h82, 8'h23);
        op(cra_pkg::CRA_OP_XD_WR, 8'h77, 3'h0, 3'h1);
        op(cra_pkg::CRA_OP_REG_WR, 8'h40, 3'h1, 3'h1);
        op(cra_pkg::CRA_OP_PX_WR, 8'h5A, 3'h1, 3'h1);
        wr(8'h83, 8'h00);
        wr(8'h82, 8'h40);
        op(cra_pkg::CRA_OP_XD_RD, 8'h00, 3'h0, 3'h1);
        `CHK("paged overlap", 8'h5A, res)
        wr(8'h83, 8'h01);
        wr(8'h82, 8'h23);
        op(cra_pkg::CRA_OP_XD_RD, 8'h00, 3'h0, 3'h1);
        `CHK("long space", 8'h77, res)
        @(posedge mclk);
        ext_sel <= 1'b1;
        op(cra_pkg::CRA_OP_PX_RD, 8'h00, 3'h1, 3'h1);
        `CHK("external", 9'h1FF, {rx, res})
        op(cra_pkg::CRA_OP_XD_WR, 8'h11, 3'h0, 3'h1);
        `CHK("ext write flag", 1'b1, rx)
        @(posedge mclk);
        ext_sel <= 1'b0;
        op(cra_pkg::CRA_OP_XD_RD, 8'h00, 3'h0, 3'h1);
        `CHK("ext write dropped", 9'h077, {rx, res})
        op(cra_pkg::CRA_OP_PX_RD, 8'h00, 3'h1, 3'h1);
        `CHK("paged read", 8'h5A, res)
    endtask
    task automatic t_code();
        @(posedge mclk);
        acc <= 8'hF0;
        op_pc <= 16'hFFF8;
        op(cra_pkg::CRA_OP_CODE_DP, 8'h00, 3'h0, 3'h1);
        `CHK("code data_pointer_pair", 17'h10213, {cr, code_addr})
        op(cra_pkg::CRA_OP_JMP_DP, 8'h00, 3'h0, 3'h1);
        `CHK("jump", 17'h10213, {jv, jmp_target})
        op(cra_pkg::CRA_OP_CODE_PC, 8'h00, 3'h0, 3'h1);
        `CHK("code pc", 17'h100E8, {cr, code_addr})
        op(cra_pkg::CRA_OP_FETCH, 8'h00, 3'h0, 3'h1);
        `CHK("fetch", 17'h1FFF8, {cr, code_addr})
    endtask
    task automatic t_carry();
        cra_pkg::cra_op_t cs [6] = '{cra_pkg::CRA_OP_SETC,
            cra_pkg::CRA_OP_ANLC, cra_pkg::CRA_OP_ANLC, cra_pkg::CRA_OP_ORLC,
            cra_pkg::CRA_OP_ORLC, cra_pkg::CRA_OP_CLRC};
        logic [5:0] dv = 6'b010010, ev = 6'b010011;
        for (int i = 0; i < 6; i++) begin
            op(cs[i], {7'h00, dv[i]}, 3'h0, 3'h1);
            `CHK("carry", ev[i], psw_out[7])
        end
        op(cra_pkg::CRA_OP_FLAGS, 8'h05, 3'h0, 3'h1);
        `CHK("flags", 3'b101, {psw_out[7], psw_out[6], psw_out[2]})
    endtask
    task automatic t_timing();
        for (int n = 0; n < 8; n++) begin
            op(cra_pkg::CRA_OP_NONE, 8'h00, 3'h0, 3'(n));
            `CHK("slot length", (n < 2 ? 1 : n), nd)
        end
    endtask
    // mid-run reset returns the pointer and status word to defaults
    task automatic t_reset();
        wr(8'hD0, 8'hE6);
        wr(8'h83, 8'h5C);
        @(posedge mclk);
        rst <= 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        rdr(8'hD0);
        `CHK("psw after reset", 8'h00, rd)
        rdr(8'h83);
        `CHK("dph after reset", 8'h00, rd)
    endtask
    // reset for 20 clocks, then every scenario in turn
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_regs();
        t_parity();
        t_banks();
        t_indirect();
        t_stack();
        t_expanded_ram();
        t_code();
        t_carry();
        t_timing();
        t_reset();
        end_sim();
    end
endmodule
